// ---- scds_top.v ----
// status clock divider select: apb registers, channel 7 divider and status pin clock path
// Function
// R01 - channel 7 divides by setting plus one
// R02 - divider acts only with synthesizer source
// R03 - channel 7 setting resets to 0x05
// R04 - each status pin picks divider a or b
// R05 - se dividers fed by either synth pre-divider
// R06 - second synth pre-divider: off, 4, 5
// R07 - first synth pre-divider: off, 4, 5
// R08 - pin b source select, resets normal
// R09 - pin a source select, resets normal
// R10 - reference source bypasses channel 7 divider
// R11 - dividers count continuously; disabled holds static
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "scds_map.vh"
module scds_top #(
  parameter RATIO_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire first_synth_tick,
  input wire second_synth_tick,
  input wire primary_ref_tick,
  input wire secondary_ref_tick,
  input wire [1:0] ch7_source_sel,
  input wire [RATIO_W-1:0] se_div_a_setting,
  input wire [RATIO_W-1:0] se_div_b_setting,
  input wire status_a_normal,
  input wire status_b_normal,
  output reg ch7_clk_tick,
  output wire status_pin_a_out,
  output wire status_pin_a_oe,
  output wire status_pin_b_out,
  output wire status_pin_b_oe
);

  // register decode results
  localparam DEC_NONE = 3'h0;
  localparam DEC_CH7 = 3'h1;
  localparam DEC_ROUTE = 3'h2;
  localparam DEC_SE_SRC = 3'h3;
  localparam DEC_LIVE = 3'h4;

  // configuration registers
  reg [7:0] ch7_ratio_reg;
  reg [7:0] route_ctrl_reg;
  reg se_source_reg;
  wire [1:0] second_synth_se_prescale_sel;
  wire [1:0] first_synth_se_prescale_sel;
  wire [1:0] status_pin_b_source_sel;
  wire [1:0] status_pin_a_source_sel;
  wire [2:0] wr_dec;
  wire [2:0] rd_dec;
  wire wr_access;
  wire rd_setup;
  wire unmapped;
  wire [2:0] first_pre_m1;
  wire [2:0] second_pre_m1;
  wire first_pre_run;
  wire second_pre_run;
  wire first_pre_tick;
  wire second_pre_tick;
  wire se_feed_tick;
  wire [RATIO_W-1:0] se_a_m1;
  wire [RATIO_W-1:0] se_b_m1;
  wire [1:0] se_run;
  wire [1:0] se_level;
  wire ch7_synth_src;
  wire ch7_in_tick;
  wire ch7_div_tick;
  wire ch7_ref_tick;
  wire [31:0] live_state;

  // address decode, shared by the write and read paths
  function [2:0] addr_decode;
    input [9:0] addr;
    begin
      case (addr)
        `SCDS_ADDR_CH7_RATIO: addr_decode = DEC_CH7;
        `SCDS_ADDR_ROUTE_CTRL: addr_decode = DEC_ROUTE;
        `SCDS_ADDR_SE_SOURCE: addr_decode = DEC_SE_SRC;
        `SCDS_ADDR_LIVE_STATE: addr_decode = DEC_LIVE;
        default: addr_decode = DEC_NONE;
      endcase
    end
  endfunction

  // pre-divider select to ratio minus one; reserved code reads as off
  function [2:0] prescale_m1;
    input [1:0] sel;
    begin
      case (sel)
        `SCDS_PRESCALE_DIV4: prescale_m1 = `SCDS_PRESCALE_M1_DIV4;
        `SCDS_PRESCALE_DIV5: prescale_m1 = `SCDS_PRESCALE_M1_DIV5;
        default: prescale_m1 = 3'h0;
      endcase
    end
  endfunction

  // pre-divider runs only for the two valid ratio codes
  function prescale_on;
    input [1:0] sel;
    begin
      prescale_on = (sel == `SCDS_PRESCALE_DIV4) | (sel == `SCDS_PRESCALE_DIV5);
    end
  endfunction

  // se divider setting: zero stops it, small values clamp to the least ratio
  function [RATIO_W-1:0] se_ratio_m1;
    input [RATIO_W-1:0] setting;
    begin
      if (setting <= `SCDS_SE_MIN_M1)
        se_ratio_m1 = `SCDS_SE_MIN_M1;
      else
        se_ratio_m1 = setting;
    end
  endfunction

  // apb handshake: zero wait states, error on unmapped addresses
  assign pready = 1'b1;
  assign wr_dec = addr_decode(paddr);
  assign rd_dec = wr_dec;
  assign unmapped = (wr_dec == DEC_NONE);
  assign pslverr = psel & penable & unmapped;
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // register writes take effect at the access edge only
  // the live state word is read only, a write to it is dropped
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch7_ratio_reg <= `SCDS_RST_CH7_RATIO; // R03
      route_ctrl_reg <= `SCDS_RST_ROUTE_CTRL; // R06 R07 R08 R09
      se_source_reg <= `SCDS_RST_SE_SOURCE;
    end
    else if (wr_access)
    begin
      case (wr_dec)
        DEC_CH7: ch7_ratio_reg <= pwdata[7:0];
        DEC_ROUTE: route_ctrl_reg <= pwdata[7:0];
        DEC_SE_SRC: se_source_reg <= pwdata[0];
        default: ;
      endcase
    end
  end

  // read data is latched in the setup cycle so prdata comes from a flop
  // an unmapped offset reads as zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
    begin
      case (rd_dec)
        DEC_CH7: prdata <= {24'h000000, ch7_ratio_reg};
        DEC_ROUTE: prdata <= {24'h000000, route_ctrl_reg};
        DEC_SE_SRC: prdata <= {31'h00000000, se_source_reg};
        DEC_LIVE: prdata <= live_state;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // route control fields
  assign second_synth_se_prescale_sel = route_ctrl_reg[`SCDS_SECOND_PRESCALE_MSB:`SCDS_SECOND_PRESCALE_LSB];
  assign first_synth_se_prescale_sel = route_ctrl_reg[`SCDS_FIRST_PRESCALE_MSB:`SCDS_FIRST_PRESCALE_LSB];
  assign status_pin_b_source_sel = route_ctrl_reg[`SCDS_PIN_B_SRC_MSB:`SCDS_PIN_B_SRC_LSB];
  assign status_pin_a_source_sel = route_ctrl_reg[`SCDS_PIN_A_SRC_MSB:`SCDS_PIN_A_SRC_LSB];

  // pre-divider ratios and enables
  assign first_pre_m1 = prescale_m1(first_synth_se_prescale_sel); // R07
  assign first_pre_run = prescale_on(first_synth_se_prescale_sel); // R07
  assign second_pre_m1 = prescale_m1(second_synth_se_prescale_sel); // R06
  assign second_pre_run = prescale_on(second_synth_se_prescale_sel); // R06

  // first synthesizer single-ended pre-divider
  scds_tick_div #(
    .W(3)
  ) u_first_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(first_pre_run),
    .in_tick(first_synth_tick),
    .ratio_m1(first_pre_m1),
    .out_tick(first_pre_tick),
    .out_level()
  );

  // second synthesizer single-ended pre-divider
  scds_tick_div #(
    .W(3)
  ) u_second_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(second_pre_run),
    .in_tick(second_synth_tick),
    .ratio_m1(second_pre_m1),
    .out_tick(second_pre_tick),
    .out_level()
  );

  // feed of the single-ended dividers from one pre-divider
  assign se_feed_tick = se_source_reg ? second_pre_tick : first_pre_tick; // R05

  // a zero setting stops a divider, other small ones clamp
  assign se_a_m1 = se_ratio_m1(se_div_a_setting);
  assign se_b_m1 = se_ratio_m1(se_div_b_setting);
  assign se_run[0] = (se_div_a_setting != `SCDS_SE_OFF);
  assign se_run[1] = (se_div_b_setting != `SCDS_SE_OFF);

  // single_ended_divider_a and single_ended_divider_b
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_se_div
      scds_tick_div #(
        .W(RATIO_W)
      ) u_se_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(se_run[gi]), // R11
        .in_tick(se_feed_tick),
        .ratio_m1((gi == 0) ? se_a_m1 : se_b_m1),
        .out_tick(),
        .out_level(se_level[gi])
      );
    end
  endgenerate

  // channel 7 source: synthesizers go through the divider, references bypass it
  assign ch7_synth_src = (ch7_source_sel == `SCDS_CH7_FIRST_SYNTH) |
                         (ch7_source_sel == `SCDS_CH7_SECOND_SYNTH); // R02
  assign ch7_in_tick = (ch7_source_sel == `SCDS_CH7_SECOND_SYNTH) ? second_synth_tick : first_synth_tick;
  assign ch7_ref_tick = (ch7_source_sel == `SCDS_CH7_SECONDARY_REF) ? secondary_ref_tick : primary_ref_tick;

  // channel 7 output divider, divide by setting plus one
  scds_tick_div #(
    .W(8)
  ) u_ch7_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(ch7_synth_src), // R02
    .in_tick(ch7_in_tick),
    .ratio_m1(ch7_ratio_reg), // R01
    .out_tick(ch7_div_tick),
    .out_level()
  );

  // output stage; bypass path has one cycle of latency, the divider path two
  // a source switch can cut or stretch one channel 7 period
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch7_clk_tick <= 1'b0;
    else if (ch7_synth_src)
      ch7_clk_tick <= ch7_div_tick; // R01
    else
      ch7_clk_tick <= ch7_ref_tick; // R10
  end

  // status pin a multiplexer
  // both pins share the two divided levels, so they stay in phase
  scds_pin_route u_pin_a (
    .pclk(pclk),
    .presetn(presetn),
    .source_sel(status_pin_a_source_sel), // R09
    .div_a_level(se_level[0]), // R04
    .div_b_level(se_level[1]), // R04
    .normal_status(status_a_normal),
    .pin_out(status_pin_a_out),
    .pin_oe(status_pin_a_oe)
  );

  // status pin b multiplexer
  scds_pin_route u_pin_b (
    .pclk(pclk),
    .presetn(presetn),
    .source_sel(status_pin_b_source_sel), // R08
    .div_a_level(se_level[0]), // R04
    .div_b_level(se_level[1]), // R04
    .normal_status(status_b_normal),
    .pin_out(status_pin_b_out),
    .pin_oe(status_pin_b_oe)
  );

  // live state for software; pulses are too short to see, levels only
  assign live_state = {24'h000000,
                       ch7_synth_src, // bit 7
                       second_pre_run, // bit 6
                       first_pre_run, // bit 5
                       se_level[1], // bit 4
                       se_level[0], // bit 3
                       status_pin_b_oe, // bit 2
                       status_pin_a_oe, // bit 1
                       1'b0};

endmodule // scds_top

// ---- scds_map.vh ----
// register map, field positions, reset values and encodings of the status clock block
`ifndef SCDS_MAP_VH
`define SCDS_MAP_VH

// register indices; byte address is four times the index
`define SCDS_IDX_CH7_RATIO 8'h2c
`define SCDS_IDX_ROUTE_CTRL 8'h2d
`define SCDS_IDX_SE_SOURCE 8'h30
`define SCDS_IDX_LIVE_STATE 8'h31
`define SCDS_ADDR_CH7_RATIO 10'h0b0
`define SCDS_ADDR_ROUTE_CTRL 10'h0b4
`define SCDS_ADDR_SE_SOURCE 10'h0c0
`define SCDS_ADDR_LIVE_STATE 10'h0c4

// reset values
`define SCDS_RST_CH7_RATIO 8'h05
`define SCDS_RST_ROUTE_CTRL 8'h0a
`define SCDS_RST_SE_SOURCE 1'h0

// route control field positions
`define SCDS_SECOND_PRESCALE_MSB 7
`define SCDS_SECOND_PRESCALE_LSB 6
`define SCDS_FIRST_PRESCALE_MSB 5
`define SCDS_FIRST_PRESCALE_LSB 4
`define SCDS_PIN_B_SRC_MSB 3
`define SCDS_PIN_B_SRC_LSB 2
`define SCDS_PIN_A_SRC_MSB 1
`define SCDS_PIN_A_SRC_LSB 0

// pre-divider select codes and their ratios minus one
`define SCDS_PRESCALE_OFF 2'h0
`define SCDS_PRESCALE_DIV4 2'h1
`define SCDS_PRESCALE_DIV5 2'h2
`define SCDS_PRESCALE_M1_DIV4 3'h3
`define SCDS_PRESCALE_M1_DIV5 3'h4

// status pin source codes
`define SCDS_PIN_FROM_DIV_A 2'h0
`define SCDS_PIN_FROM_DIV_B 2'h1
`define SCDS_PIN_NORMAL 2'h2
`define SCDS_PIN_OFF 2'h3

// channel 7 source codes
`define SCDS_CH7_FIRST_SYNTH 2'h0
`define SCDS_CH7_SECOND_SYNTH 2'h1
`define SCDS_CH7_PRIMARY_REF 2'h2
`define SCDS_CH7_SECONDARY_REF 2'h3

// single-ended divider settings below this ratio-minus-one clamp to it
`define SCDS_SE_MIN_M1 8'h05
`define SCDS_SE_OFF 8'h00

`endif

// ---- scds_tick_div.v ----
// programmable tick divider: one output tick per ratio_m1+1 input ticks
`timescale 1ns/1ps
module scds_tick_div #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire in_tick,
  input wire [W-1:0] ratio_m1,
  output reg out_tick,
  output reg out_level
);

  reg [W-1:0] cnt_reg;
  reg [W-1:0] cnt_next;
  wire wrap;

  // wrap compares with >= so a ratio lowered mid-count cannot run away
  assign wrap = (cnt_reg >= ratio_m1);

  // next count value
  always @*
  begin
    cnt_next = cnt_reg;
    if (in_tick)
    begin
      if (wrap)
        cnt_next = {W{1'b0}};
      else
        cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // free-running count on the input ticks; stopped divider clears its count and holds both outputs low
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= {W{1'b0}};
      out_tick <= 1'b0;
      out_level <= 1'b0;
    end
    else if (!run)
    begin
      cnt_reg <= {W{1'b0}};
      out_tick <= 1'b0; // R11
      out_level <= 1'b0; // R11
    end
    else
    begin
      cnt_reg <= cnt_next; // R11
      out_tick <= in_tick & wrap;
      // high for the first half of each period
      out_level <= (cnt_next <= (ratio_m1 >> 1));
    end
  end

endmodule // scds_tick_div

// ---- scds_pin_route.v ----
// per status pin source multiplexer with registered pin drive
`timescale 1ns/1ps
`include "scds_map.vh"
module scds_pin_route (
  input wire pclk,
  input wire presetn,
  input wire [1:0] source_sel,
  input wire div_a_level,
  input wire div_b_level,
  input wire normal_status,
  output reg pin_out,
  output reg pin_oe
);

  // registered so the pin never glitches on a select change
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      case (source_sel)
        `SCDS_PIN_FROM_DIV_A:
        begin
          pin_out <= div_a_level;
          pin_oe <= 1'b1;
        end
        `SCDS_PIN_FROM_DIV_B:
        begin
          pin_out <= div_b_level;
          pin_oe <= 1'b1;
        end
        `SCDS_PIN_NORMAL:
        begin
          pin_out <= normal_status;
          pin_oe <= 1'b1;
        end
        default:
        begin
          pin_out <= 1'b0; // pin disabled, not driven
          pin_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule // scds_pin_route

// ---- scds_checker.sv ----
// checker: port assertions for the status clock block
`timescale 1ns/1ps
`include "scds_map.vh"
module scds_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire first_synth_tick,
  input wire primary_ref_tick,
  input wire [1:0] ch7_source_sel,
  input wire status_a_normal,
  input wire status_b_normal,
  input wire ch7_clk_tick,
  input wire status_pin_a_out,
  input wire status_pin_a_oe,
  input wire status_pin_b_out,
  input wire status_pin_b_oe
);
  reg [7:0] route_reg;
  // route shadow, follows writes on the access edge only
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      route_reg <= `SCDS_RST_ROUTE_CTRL;
    else if (psel && penable && pwrite && paddr == `SCDS_ADDR_ROUTE_CTRL)
      route_reg <= pwdata[7:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a reference tick while bypassing
  sequence ref_tick_s;
    ch7_source_sel == `SCDS_CH7_PRIMARY_REF && primary_ref_tick;
  endsequence
  ref_pass_a: assert property (ref_tick_s |=> ch7_clk_tick)
    else $error("bypass tick missing");
  ref_quiet_a: assert property (ch7_source_sel == 2'h2 && !primary_ref_tick |=> !ch7_clk_tick)
    else $error("bypass tick without cause");
  // synth output only two cycles after an input tick
  synth_cause_a: assert property (ch7_clk_tick && $past(ch7_source_sel, 2) == 2'h0 && $past(ch7_source_sel) == 2'h0
    |-> $past(first_synth_tick, 2))
    else $error("channel tick without synth tick");
  pin_a_norm_a: assert property (route_reg[1:0] == 2'h2 |=> status_pin_a_oe && status_pin_a_out == $past(status_a_normal))
    else $error("pin a not showing status");
  pin_b_norm_a: assert property (route_reg[3:2] == 2'h2 |=> status_pin_b_oe && status_pin_b_out == $past(status_b_normal))
    else $error("pin b not showing status");
  pin_a_off_a: assert property (route_reg[1:0] == 2'h3 |=> !status_pin_a_oe && !status_pin_a_out)
    else $error("pin a driven while off");
  pin_b_off_a: assert property (route_reg[3:2] == 2'h3 |=> !status_pin_b_oe && !status_pin_b_out)
    else $error("pin b driven while off");
  pin_b_clk_a: assert property (route_reg[3:2] < 2'h2 |=> status_pin_b_oe)
    else $error("pin b clock not driven");
endmodule // scds_checker
bind scds_top scds_checker scds_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .first_synth_tick(first_synth_tick),
  .primary_ref_tick(primary_ref_tick), .ch7_source_sel(ch7_source_sel), .status_a_normal(status_a_normal),
  .status_b_normal(status_b_normal), .ch7_clk_tick(ch7_clk_tick), .status_pin_a_out(status_pin_a_out),
  .status_pin_a_oe(status_pin_a_oe), .status_pin_b_out(status_pin_b_out), .status_pin_b_oe(status_pin_b_oe));

// ---- testbench.sv ----
// testbench: directed and random checks of the status clock block
`timescale 1ns/1ps
`include "scds_map.vh"
module testbench;
  reg pclk = 1'h0;
  reg presetn = 1'h0;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [9:0] paddr = 10'h000;
  reg [31:0] pwdata = 32'h0, r, rv, rnd;
  reg first_synth_tick = 1'h1, second_synth_tick = 1'h1, secondary_ref_tick = 1'h1;
  reg primary_ref_tick = 1'h0, status_a_normal = 1'h0, status_b_normal = 1'h0;
  reg [1:0] ch7_source_sel = 2'h0;
  reg [7:0] se_div_a_setting = 8'h05, se_div_b_setting = 8'h05, v;
  wire pready, pslverr, ch7_clk_tick, pa, pa_oe, pb, pb_oe;
  wire [31:0] prdata;
  wire [2:0] obs = {ch7_clk_tick, pb, pa};
  reg e, tick_rand = 1'h0, t1 = 1'h0, t2 = 1'h0;
  integer seed = 32'he5e0, bad_count = 0, tests_run = 0, i, p;

  scds_top scds_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .first_synth_tick(first_synth_tick), .second_synth_tick(second_synth_tick),
    .primary_ref_tick(primary_ref_tick), .secondary_ref_tick(secondary_ref_tick),
    .ch7_source_sel(ch7_source_sel), .se_div_a_setting(se_div_a_setting), .se_div_b_setting(se_div_b_setting),
    .status_a_normal(status_a_normal), .status_b_normal(status_b_normal), .ch7_clk_tick(ch7_clk_tick),
    .status_pin_a_out(pa), .status_pin_a_oe(pa_oe), .status_pin_b_out(pb), .status_pin_b_oe(pb_oe));

  initial forever #25 pclk = ~pclk;

  // random primary reference ticks and status levels; first synthesizer ticks when asked
  always @(posedge pclk)
  begin
    rnd = $random(seed);
    primary_ref_tick <= rnd[0];
    first_synth_tick <= tick_rand ? rnd[3] : 1'h1;
    status_a_normal <= rnd[1];
    status_b_normal <= rnd[2];
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one apb transfer; request held until pready is seen
  task apb(input w, input [9:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'h1)
        bad_count = bad_count + 1;
      e = pslverr;
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // third interval between events; first two may straddle the change
  task meas(input integer w, output integer per);
    integer n, k;
    reg prev, hit;
    begin
      prev = obs[w];
      for (k = 0; k < 3; k = k + 1)
      begin
        n = 0;
        hit = 1'h0;
        while (!hit && n < 1500)
        begin
          @(posedge pclk);
          n = n + 1;
          hit = obs[w] && (w == 2 || !prev);
          prev = obs[w];
        end
        per = hit ? n : 0;
      end
    end
  endtask

  // expected pin period in cycles, zero when the pin stays static
  function integer pin_period(input [7:0] rt, input src, input [7:0] da, input [7:0] db, input integer w);
    reg [1:0] pre, pin;
    reg [7:0] s;
    begin
      pre = src ? rt[7:6] : rt[5:4];
      pin = w ? rt[3:2] : rt[1:0];
      s = pin[0] ? db : da;
      pin_period = (pin[1] || s == 8'h00 || pre == 2'h0 || pre == 2'h3) ? 0
        : (pre == 2'h1 ? 4 : 5) * (s < 8'h06 ? 6 : s + 1);
    end
  endfunction

  task cfg(input [7:0] rt, input src, input [7:0] da, input [7:0] db, input integer w);
    begin
      se_div_a_setting <= da;
      se_div_b_setting <= db;
      apb(1'h1, `SCDS_ADDR_SE_SOURCE, {31'h0, src}, r);
      apb(1'h1, `SCDS_ADDR_ROUTE_CTRL, {24'h0, rt}, r);
      meas(w, p);
      chk(p, pin_period(rt, src, da, db, w));
    end
  endtask

  task complete_run;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // hang guard, far above the longest run
  initial
  begin
    repeat (60000) @(posedge pclk);
    bad_count = bad_count + 1;
    complete_run;
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `SCDS_ADDR_CH7_RATIO, 32'h0, r);
    chk(r, {24'h0, `SCDS_RST_CH7_RATIO});
    chk({31'h0, e}, 32'h0);
    apb(1'h0, `SCDS_ADDR_ROUTE_CTRL, 32'h0, r);
    chk(r, 32'h0000000a);
    chk({31'h0, pa_oe & pb_oe}, 32'h1);
    apb(1'h0, `SCDS_ADDR_LIVE_STATE, 32'h0, r);
    chk(r & 32'h000000e6, 32'h00000086);
    apb(1'h0, 10'h3fc, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    // corner ratios then random ones, alternating synthesizer
    for (i = 0; i < 7; i = i + 1)
    begin
      rv = $random(seed);
      v = i == 0 ? 8'h00 : i == 1 ? 8'hff : i == 2 ? 8'h05 : rv[7:0];
      ch7_source_sel <= {1'h0, i[0]};
      apb(1'h1, `SCDS_ADDR_CH7_RATIO, {24'h0, v}, r);
      apb(1'h0, `SCDS_ADDR_CH7_RATIO, 32'h0, r);
      chk(r, {24'h0, v});
      meas(2, p);
      chk(p, v + 1);
    end
    $display("test ratio done");
    // random first synthesizer ticks at ratio 0: each returns two cycles later
    ch7_source_sel <= `SCDS_CH7_FIRST_SYNTH;
    apb(1'h1, `SCDS_ADDR_CH7_RATIO, 32'h0, r);
    tick_rand <= 1'h1;
    for (i = 0; i < 300; i = i + 1)
    begin
      @(posedge pclk);
      if (i > 3)
        chk({31'h0, ch7_clk_tick}, {31'h0, t2});
      t2 = t1;
      t1 = first_synth_tick;
    end
    tick_rand <= 1'h0;
    $display("test tick done");
    ch7_source_sel <= `SCDS_CH7_PRIMARY_REF;
    repeat (50) @(posedge pclk);
    ch7_source_sel <= `SCDS_CH7_SECONDARY_REF;
    meas(2, p);
    chk(p, 1);
    $display("test bypass done");
    cfg(8'h18, 1'h0, 8'h05, 8'h09, 0);
    cfg(8'h26, 1'h0, 8'h05, 8'h06, 1);
    cfg(8'h49, 1'h1, 8'h05, 8'h09, 0);
    cfg(8'h82, 1'h1, 8'h01, 8'h06, 1);
    cfg(8'h08, 1'h1, 8'h05, 8'h06, 0);
    cfg(8'h0f, 1'h0, 8'h05, 8'h06, 0);
    $display("test route done");
    complete_run;
  end
endmodule // testbench
